// File: verilog/pctc_pkg.sv
// Constants for the per-channel tristate control block
`default_nettype none
package pctc_pkg;
  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int CNT_W = 12;
  localparam logic [11:0] CNT_LAST = 12'hfff;
  localparam logic [11:0] CNT_STEP = 12'h001;
  localparam logic [11:0] CNT_ZERO = 12'h000;
  localparam logic [11:0] BP_LEAD = 12'h024;
  localparam logic [11:0] LC_LEAD = 12'h020;
  localparam int LC_ENTRIES = 4096;
  localparam int BP_ENTRIES = 4096;
  localparam logic [4:0] LC_STREAMS = 5'h1c;
  localparam logic [4:0] LC_FIRST_FORCED = 5'h13;
  localparam int LC_NSTREAMS = 28;
  // ****************************************
  // Local stream rates
  // ****************************************
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  // ****************************************
  // Channel mode field codes
  // ****************************************
  localparam logic [2:0] MODE_CONN_VAR = 3'h0;
  localparam logic [2:0] MODE_CONN_CONST = 3'h1;
  localparam logic [2:0] MODE_MSG = 3'h2;
  localparam logic [2:0] MODE_HIZ = 3'h3;
  localparam logic [2:0] MODE_BER = 3'h4;
  // ****************************************
  // Connection memory entry layout
  // ****************************************
  localparam int ENTRY_W = 18;
  localparam int MODE_LSB = 0;
  localparam int SSTRM_LSB = 3;
  localparam int SCHAN_LSB = 8;
  localparam int MSG_LSB = 0;
  localparam int SUBR_LSB = 16;
  localparam logic [17:0] ENTRY_RESET = 18'h00003;
endpackage : pctc_pkg
`default_nettype wire

// File: verilog/pctc_top.sv
// Per-channel tristate control streams and local connection memory
// Functional notes
// - Separate backplane and local tristate control outputs
// - Each stream carries 4096 bits per frame
// - Each bit position maps to stream/channel
// - High bit floats channel, low drives data
// - Backplane bit 0 leads frame by 36 (8M)
// - Backplane bit 0 leads frame by 36 (16M)
// - Local frame is 128 slots of 32 bits
// - Local slot 0 leads frame by 32
// - 8M local: slot N is channel N
// - Higher local outputs driven low at 8/4M
// - 4M local: only even slots used
// - 2M local: only every fourth slot used
// - Mixed rates map per stream rate
// - Local memory has high and low parts
// - Three-bit mode field selects channel mode
// - Source stream and channel fields select input
// - Message mode sends low eight bits
// - Two-bit field picks sub-rate bit positions
`timescale 1ns/1ns
`default_nettype none
module pctc_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Link pins
  input wire logic FAST_OUTPUT_CLOCK_I,
  input wire logic BP_FRAME_I,
  input wire logic LOCAL_FRAME_I,
  // Configuration
  input wire logic BP_RATE16_I,
  input wire logic [55:0] LOCAL_RATE_I,
  // Backplane float bit write port
  input wire logic BP_WR_I,
  input wire logic [4:0] BP_STREAM_I,
  input wire logic [7:0] BP_CHAN_I,
  input wire logic BP_HIZ_I,
  // Local connection memory port
  input wire logic LCM_WR_I,
  input wire logic LCM_RD_I,
  input wire logic [4:0] LCM_STREAM_I,
  input wire logic [6:0] LCM_CHAN_I,
  input wire logic [15:0] LCM_LOW_I,
  input wire logic [1:0] LCM_HIGH_I,
  // Local connection memory read answer
  output logic LCM_RD_VALID_O,
  output logic [2:0] LOCAL_CHANNEL_MODE_FIELD_O,
  output logic [4:0] SOURCE_STREAM_FIELD_O,
  output logic [7:0] SOURCE_CHANNEL_FIELD_O,
  output logic [7:0] MSG_BYTE_O,
  output logic [1:0] SUBRATE_BIT_SELECT_O,
  output logic MSG_MODE_O,
  output logic HIZ_MODE_O,
  // Control streams
  output logic BACKPLANE_TRISTATE_CTL_OUT_O,
  output logic LOCAL_TRISTATE_CTL_OUT_O,
  output logic [27:0] LOCAL_FORCE_LOW_O
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [11:0] bp_pos(input logic r16, input logic [4:0] s,
                                         input logic [7:0] c);
    if (r16) begin
      bp_pos = {c[7:0], s[3:0]};
    end else begin
      bp_pos = {c[6:0], s[4:0]};
    end
  endfunction : bp_pos

  function automatic logic slot_used(input logic [1:0] r, input logic [6:0] slot);
    case (r)
      pctc_pkg::RATE_8M: slot_used = 1'b1;
      pctc_pkg::RATE_4M: slot_used = ~slot[0];
      pctc_pkg::RATE_2M: slot_used = (slot[1:0] == 2'h0);
      default: slot_used = 1'b0;
    endcase
  endfunction : slot_used

  function automatic logic [6:0] slot_chan(input logic [1:0] r, input logic [6:0] slot);
    case (r)
      pctc_pkg::RATE_4M: slot_chan = {1'b0, slot[6:1]};
      pctc_pkg::RATE_2M: slot_chan = {2'h0, slot[6:2]};
      default: slot_chan = slot;
    endcase
  endfunction : slot_chan

  function automatic logic forced_low(input logic [4:0] s, input logic [1:0] r);
    forced_low = (s >= pctc_pkg::LC_FIRST_FORCED) && (r != pctc_pkg::RATE_2M);
  endfunction : forced_low

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  logic fclk_s1_q, fclk_s2_q, fclk_s3_q;
  logic bfr_s1_q, bfr_s2_q, bfr_s3_q;
  logic lfr_s1_q, lfr_s2_q, lfr_s3_q;
  logic fast_rise, bp_frame_rise, lc_frame_rise;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      {fclk_s1_q, fclk_s2_q, fclk_s3_q} <= 3'h0;
      {bfr_s1_q, bfr_s2_q, bfr_s3_q} <= 3'h0;
      {lfr_s1_q, lfr_s2_q, lfr_s3_q} <= 3'h0;
    end else begin
      {fclk_s1_q, fclk_s2_q, fclk_s3_q} <= {FAST_OUTPUT_CLOCK_I, fclk_s1_q, fclk_s2_q};
      {bfr_s1_q, bfr_s2_q, bfr_s3_q} <= {BP_FRAME_I, bfr_s1_q, bfr_s2_q};
      {lfr_s1_q, lfr_s2_q, lfr_s3_q} <= {LOCAL_FRAME_I, lfr_s1_q, lfr_s2_q};
    end
  end

  assign fast_rise = fclk_s2_q & ~fclk_s3_q;
  assign bp_frame_rise = bfr_s2_q & ~bfr_s3_q;
  assign lc_frame_rise = lfr_s2_q & ~lfr_s3_q;

  // ****************************************
  // Bit position counters
  // ****************************************
  // Loading the lead at the boundary puts bit 0 that many clocks ahead of it
  logic [11:0] bp_cnt_q, lc_cnt_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      bp_cnt_q <= pctc_pkg::CNT_ZERO;
    end else if (bp_frame_rise) begin
      bp_cnt_q <= pctc_pkg::BP_LEAD;
    end else if (fast_rise) begin
      bp_cnt_q <= bp_cnt_q + pctc_pkg::CNT_STEP;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      lc_cnt_q <= pctc_pkg::CNT_ZERO;
    end else if (lc_frame_rise) begin
      lc_cnt_q <= pctc_pkg::LC_LEAD;
    end else if (fast_rise) begin
      lc_cnt_q <= lc_cnt_q + pctc_pkg::CNT_STEP;
    end
  end

  // ****************************************
  // Backplane float bits
  // ****************************************
  logic bp_hiz_mem [0:pctc_pkg::BP_ENTRIES-1];

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < pctc_pkg::BP_ENTRIES; i++) begin
        bp_hiz_mem[i] <= 1'b1;
      end
    end else if (BP_WR_I) begin
      bp_hiz_mem[bp_pos(BP_RATE16_I, BP_STREAM_I, BP_CHAN_I)] <= BP_HIZ_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      BACKPLANE_TRISTATE_CTL_OUT_O <= 1'b1;
    end else begin
      BACKPLANE_TRISTATE_CTL_OUT_O <= bp_hiz_mem[bp_cnt_q];
    end
  end

  // ****************************************
  // Local connection memory
  // ****************************************
  // High part in bits 17:16, low part in 15:0; resets to float so nothing drives
  logic [17:0] lcm_mem [0:pctc_pkg::LC_ENTRIES-1];
  logic [11:0] host_addr;

  assign host_addr = {LCM_STREAM_I, LCM_CHAN_I};

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < pctc_pkg::LC_ENTRIES; i++) begin
        lcm_mem[i] <= pctc_pkg::ENTRY_RESET;
      end
    end else if (LCM_WR_I) begin
      lcm_mem[host_addr] <= {LCM_HIGH_I, LCM_LOW_I};
    end
  end

  logic [17:0] rd_entry;
  logic [2:0] rd_mode;

  assign rd_entry = lcm_mem[host_addr];
  assign rd_mode = rd_entry[pctc_pkg::MODE_LSB +: 3];

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      LCM_RD_VALID_O <= 1'b0;
      LOCAL_CHANNEL_MODE_FIELD_O <= 3'h0;
      SOURCE_STREAM_FIELD_O <= 5'h00;
      SOURCE_CHANNEL_FIELD_O <= 8'h00;
      MSG_BYTE_O <= 8'h00;
      SUBRATE_BIT_SELECT_O <= 2'h0;
      MSG_MODE_O <= 1'b0;
      HIZ_MODE_O <= 1'b0;
    end else begin
      LCM_RD_VALID_O <= LCM_RD_I;
      if (LCM_RD_I) begin
        LOCAL_CHANNEL_MODE_FIELD_O <= rd_mode;
        SOURCE_STREAM_FIELD_O <= rd_entry[pctc_pkg::SSTRM_LSB +: 5];
        SOURCE_CHANNEL_FIELD_O <= rd_entry[pctc_pkg::SCHAN_LSB +: 8];
        MSG_BYTE_O <= rd_entry[pctc_pkg::MSG_LSB +: 8];
        SUBRATE_BIT_SELECT_O <= rd_entry[pctc_pkg::SUBR_LSB +: 2];
        MSG_MODE_O <= (rd_mode == pctc_pkg::MODE_MSG);
        HIZ_MODE_O <= (rd_mode == pctc_pkg::MODE_HIZ);
      end
    end
  end

  // ****************************************
  // Local control stream
  // ****************************************
  // Bit 4:0 of the position is the stream, 11:5 the slot
  logic [4:0] lc_strm;
  logic [6:0] lc_slot;
  logic [1:0] lc_rate;
  logic lc_hit;
  logic [11:0] lc_addr;

  assign lc_strm = lc_cnt_q[4:0];
  assign lc_slot = lc_cnt_q[11:5];
  assign lc_rate = (lc_strm < pctc_pkg::LC_STREAMS) ?
                   LOCAL_RATE_I[{lc_strm, 1'b0} +: 2] : pctc_pkg::RATE_2M;
  assign lc_hit = (lc_strm < pctc_pkg::LC_STREAMS) && !forced_low(lc_strm, lc_rate) &&
                  slot_used(lc_rate, lc_slot);
  assign lc_addr = lc_hit ? {lc_strm, slot_chan(lc_rate, lc_slot)} : pctc_pkg::CNT_ZERO;

  // Dummy positions read high so a careless consumer floats rather than drives
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      LOCAL_TRISTATE_CTL_OUT_O <= 1'b1;
    end else begin
      LOCAL_TRISTATE_CTL_OUT_O <= !lc_hit ||
        (lcm_mem[lc_addr][pctc_pkg::MODE_LSB +: 3] == pctc_pkg::MODE_HIZ);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      LOCAL_FORCE_LOW_O <= 28'h0000000;
    end else begin
      for (int s = 0; s < pctc_pkg::LC_NSTREAMS; s++) begin
        LOCAL_FORCE_LOW_O[s] <= forced_low(5'(s), LOCAL_RATE_I[2*s +: 2]);
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_bp_lead;
    @(posedge CLK_I) disable iff (!RST_B_I)
    bp_frame_rise |=> (bp_cnt_q == pctc_pkg::BP_LEAD);
  endproperty
  a_bp_lead: assert property (p_bp_lead) else $error("backplane lead wrong");

  property p_lc_lead;
    @(posedge CLK_I) disable iff (!RST_B_I)
    lc_frame_rise |=> (lc_cnt_q == pctc_pkg::LC_LEAD);
  endproperty
  a_lc_lead: assert property (p_lc_lead) else $error("local lead wrong");

  property p_bp_wrap;
    @(posedge CLK_I) disable iff (!RST_B_I)
    (bp_cnt_q == pctc_pkg::CNT_LAST && fast_rise && !bp_frame_rise) |=>
      (bp_cnt_q == pctc_pkg::CNT_ZERO);
  endproperty
  a_bp_wrap: assert property (p_bp_wrap) else $error("frame not 4096 bits");

  property p_lc_hold;
    @(posedge CLK_I) disable iff (!RST_B_I)
    (!fast_rise && !lc_frame_rise) |=> $stable(lc_cnt_q);
  endproperty
  a_lc_hold: assert property (p_lc_hold) else $error("local count moved");

  property p_lc_float;
    @(posedge CLK_I) disable iff (!RST_B_I)
    (lc_hit && lcm_mem[lc_addr][pctc_pkg::MODE_LSB +: 3] == pctc_pkg::MODE_HIZ) |=>
      LOCAL_TRISTATE_CTL_OUT_O;
  endproperty
  a_lc_float: assert property (p_lc_float) else $error("float channel driven");

  property p_lc_drive;
    @(posedge CLK_I) disable iff (!RST_B_I)
    (lc_hit && lcm_mem[lc_addr][pctc_pkg::MODE_LSB +: 3] != pctc_pkg::MODE_HIZ) |=>
      !LOCAL_TRISTATE_CTL_OUT_O;
  endproperty
  a_lc_drive: assert property (p_lc_drive) else $error("active channel floated");

  property p_four_odd;
    @(posedge CLK_I) disable iff (!RST_B_I)
    (lc_strm < pctc_pkg::LC_FIRST_FORCED && lc_rate == pctc_pkg::RATE_4M && lc_slot[0]) |->
      !lc_hit ##1 LOCAL_TRISTATE_CTL_OUT_O;
  endproperty
  a_four_odd: assert property (p_four_odd) else $error("odd slot used at 4M");

  property p_two_gap;
    @(posedge CLK_I) disable iff (!RST_B_I)
    (lc_strm < pctc_pkg::LC_STREAMS && lc_rate == pctc_pkg::RATE_2M && lc_slot[1:0] != 2'h0)
      |-> !lc_hit;
  endproperty
  a_two_gap: assert property (p_two_gap) else $error("gap slot used at 2M");

  property p_force19;
    @(posedge CLK_I) disable iff (!RST_B_I)
    (LOCAL_RATE_I[39:38] == pctc_pkg::RATE_8M) ##1 (LOCAL_RATE_I[39:38] == pctc_pkg::RATE_8M)
      |=> LOCAL_FORCE_LOW_O[19];
  endproperty
  a_force19: assert property (p_force19) else $error("stream 19 not low");

  sequence s_wr_rd;
    (LCM_WR_I && !LCM_RD_I) ##1 (LCM_RD_I && !LCM_WR_I && $stable(host_addr));
  endsequence

  property p_msg;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr_rd |=> (MSG_BYTE_O == $past(LCM_LOW_I[7:0], 2)) &&
                (SOURCE_CHANNEL_FIELD_O == $past(LCM_LOW_I[15:8], 2));
  endproperty
  a_msg: assert property (p_msg) else $error("message byte mismatch");

  property p_mode_flags;
    @(posedge CLK_I) disable iff (!RST_B_I)
    LCM_RD_VALID_O |-> (HIZ_MODE_O == (LOCAL_CHANNEL_MODE_FIELD_O == pctc_pkg::MODE_HIZ)) &&
                       (MSG_MODE_O == (LOCAL_CHANNEL_MODE_FIELD_O == pctc_pkg::MODE_MSG));
  endproperty
  a_mode_flags: assert property (p_mode_flags) else $error("mode flags wrong");

  property p_bp_hold;
    @(posedge CLK_I) disable iff (!RST_B_I)
    (!fast_rise && !bp_frame_rise) |=> $stable(bp_cnt_q);
  endproperty
  a_bp_hold: assert property (p_bp_hold) else $error("backplane count moved");

  property p_lc_wrap;
    @(posedge CLK_I) disable iff (!RST_B_I)
    (lc_cnt_q == pctc_pkg::CNT_LAST && fast_rise && !lc_frame_rise) |=>
      (lc_cnt_q == pctc_pkg::CNT_ZERO);
  endproperty
  a_lc_wrap: assert property (p_lc_wrap) else $error("local frame not 4096 bits");

  property p_rd_valid;
    @(posedge CLK_I) disable iff (!RST_B_I)
    LCM_RD_VALID_O == $past(LCM_RD_I);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read valid timing wrong");

  property p_force_off;
    @(posedge CLK_I) disable iff (!RST_B_I)
    (LOCAL_RATE_I[39:38] == pctc_pkg::RATE_2M) ##1 (LOCAL_RATE_I[39:38] == pctc_pkg::RATE_2M)
      |=> !LOCAL_FORCE_LOW_O[19];
  endproperty
  a_force_off: assert property (p_force_off) else $error("stream 19 forced at 2M");
endmodule : pctc_top
`default_nettype wire

// File: tb/pctc_partner.sv
// Model of the external drivers that consume both control streams
`timescale 1ns/1ns
`default_nettype none
module pctc_partner (
  // Link pins
  output logic link_clk_o,
  output logic bp_frame_o,
  output logic lc_frame_o,
  // Control streams
  input wire logic bp_ctl_i,
  input wire logic lc_ctl_i
);
  logic bp_seen [0:4159];
  logic lc_seen [0:4159];
  initial begin
    link_clk_o = 1'b0;
    bp_frame_o = 1'b0;
    lc_frame_o = 1'b0;
  end
  // ****************************************
  // Frame then n+1 bit cells
  // ****************************************
  // Link clock stands still between frames, so no edge races the frame
  task automatic run(input int n);
    bp_frame_o = 1'b1;
    lc_frame_o = 1'b1;
    #50;
    bp_frame_o = 1'b0;
    lc_frame_o = 1'b0;
    #50;
    for (int i = 0; i <= n; i++) begin
      // Sampled late in the cell, once the level has settled
      bp_seen[i] = bp_ctl_i;
      // Raw level kept; dummy cells are judged by the caller only
      lc_seen[i] = lc_ctl_i;
      #25;
      link_clk_o = 1'b1;
      #63;
      link_clk_o = 1'b0;
      #37;
    end
  endtask : run
endmodule : pctc_partner
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the tristate control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rst_b, bp_rate16, bp_wr, bp_hiz, lcm_wr, lcm_rd;
  logic [55:0] local_rate;
  logic [4:0] bp_stream, lcm_stream, sstrm;
  logic [7:0] bp_chan, schan, msg_b;
  logic [6:0] lcm_chan;
  logic [15:0] lcm_low;
  logic [1:0] lcm_high, subr;
  logic rd_valid, msg_m, hiz_m, bp_ctl, lc_ctl, link, bpf, lcf;
  logic [2:0] mode_f;
  logic [27:0] force_low;
  int fail_count = 0;
  int checked = 0;
  pctc_top u_pctc_top (.CLK_I(clk), .RST_B_I(rst_b), .FAST_OUTPUT_CLOCK_I(link),
    .BP_FRAME_I(bpf), .LOCAL_FRAME_I(lcf), .BP_RATE16_I(bp_rate16),
    .LOCAL_RATE_I(local_rate), .BP_WR_I(bp_wr), .BP_STREAM_I(bp_stream),
    .BP_CHAN_I(bp_chan), .BP_HIZ_I(bp_hiz), .LCM_WR_I(lcm_wr), .LCM_RD_I(lcm_rd),
    .LCM_STREAM_I(lcm_stream), .LCM_CHAN_I(lcm_chan), .LCM_LOW_I(lcm_low),
    .LCM_HIGH_I(lcm_high), .LCM_RD_VALID_O(rd_valid), .LOCAL_CHANNEL_MODE_FIELD_O(mode_f),
    .SOURCE_STREAM_FIELD_O(sstrm), .SOURCE_CHANNEL_FIELD_O(schan), .MSG_BYTE_O(msg_b),
    .SUBRATE_BIT_SELECT_O(subr), .MSG_MODE_O(msg_m), .HIZ_MODE_O(hiz_m),
    .BACKPLANE_TRISTATE_CTL_OUT_O(bp_ctl), .LOCAL_TRISTATE_CTL_OUT_O(lc_ctl),
    .LOCAL_FORCE_LOW_O(force_low));
  pctc_partner u_pctc_partner (.link_clk_o(link), .bp_frame_o(bpf), .lc_frame_o(lcf),
    .bp_ctl_i(bp_ctl), .lc_ctl_i(lc_ctl));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic mem_wr(input logic [4:0] s, input logic [6:0] c, input logic [15:0] lo,
                        input logic [1:0] hi);
    lcm_stream <= s;
    lcm_chan <= c;
    lcm_low <= lo;
    lcm_high <= hi;
    lcm_wr <= 1'b1;
    @(posedge clk);
    lcm_wr <= 1'b0;
  endtask : mem_wr
  task automatic mem_rd(input logic [4:0] s, input logic [6:0] c);
    lcm_stream <= s;
    lcm_chan <= c;
    lcm_rd <= 1'b1;
    @(posedge clk);
    lcm_rd <= 1'b0;
    #1;
    check("rd_valid", rd_valid, 1);
    @(posedge clk);
  endtask : mem_rd
  task automatic bp_put(input logic [4:0] s, input logic [7:0] c, input logic h);
    bp_stream <= s;
    bp_chan <= c;
    bp_hiz <= h;
    bp_wr <= 1'b1;
    @(posedge clk);
    bp_wr <= 1'b0;
  endtask : bp_put
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check("reset_bp_ctl", bp_ctl, 1);
    check("reset_lc_ctl", lc_ctl, 1);
    @(posedge clk);
    $display("test reset done");
  endtask : test_reset
  task automatic test_fields();
    mem_rd(5'h00, 7'h00);
    check("reset_mode", mode_f, pctc_pkg::MODE_HIZ);
    check("reset_hiz", hiz_m, 1);
    check("reset_subr", subr, 0);
    mem_wr(5'h09, 7'h7f, 16'ha55a, 2'h2);
    mem_rd(5'h09, 7'h7f);
    check("mode", mode_f, pctc_pkg::MODE_MSG);
    check("src_stream", sstrm, 5'h0b);
    check("src_chan", schan, 8'ha5);
    check("msg_byte", msg_b, 8'h5a);
    check("subrate", subr, 2'h2);
    $display("test fields done");
  endtask : test_fields
  task automatic test_modes();
    for (int m = 0; m <= 4; m++) begin
      mem_wr(5'h05, 7'h03, {13'h0000, m[2:0]}, 2'h0);
      mem_rd(5'h05, 7'h03);
      check("mode_code", mode_f, m);
      check("hiz_mode", hiz_m, m[2:0] == pctc_pkg::MODE_HIZ);
      check("msg_mode", msg_m, m[2:0] == pctc_pkg::MODE_MSG);
    end
    $display("test modes done");
  endtask : test_modes
  task automatic test_streams();
    logic [55:0] lr;
    lr = 56'h0;
    lr[1:0] = pctc_pkg::RATE_8M;
    lr[3:2] = pctc_pkg::RATE_8M;
    lr[5:4] = pctc_pkg::RATE_4M;
    lr[39:38] = pctc_pkg::RATE_8M;
    local_rate <= lr;
    bp_put(5'h04, 8'h01, 1'b0);
    mem_wr(5'h00, 7'h01, 16'h0000, 2'h0);
    @(posedge clk);
    mem_wr(5'h02, 7'h01, 16'h0000, 2'h0);
    @(posedge clk);
    mem_wr(5'h03, 7'h01, 16'h0000, 2'h0);
    @(posedge clk);
    #1;
    check("force_low", force_low, 28'h0080000);
    u_pctc_partner.run(100);
    check("bp_pos36", u_pctc_partner.bp_seen[0], 0);
    check("bp_pos37", u_pctc_partner.bp_seen[1], 1);
    check("lc_pos32", u_pctc_partner.lc_seen[0], 0);
    check("lc_pos33", u_pctc_partner.lc_seen[1], 1);
    check("lc_pos34", u_pctc_partner.lc_seen[2], 1);
    check("lc_pos66", u_pctc_partner.lc_seen[34], 0);
    check("lc_pos35", u_pctc_partner.lc_seen[3], 1);
    check("lc_pos131", u_pctc_partner.lc_seen[99], 0);
    $display("test streams done");
  endtask : test_streams
  task automatic test_rate16();
    @(posedge clk);
    bp_rate16 <= 1'b1;
    @(posedge clk);
    bp_put(5'h05, 8'h02, 1'b0);
    u_pctc_partner.run(3);
    check("bp16_pos37", u_pctc_partner.bp_seen[1], 0);
    check("bp16_pos38", u_pctc_partner.bp_seen[2], 1);
    $display("test rate16 done");
  endtask : test_rate16
  // Runs two cells past a whole frame so both counters wrap inside the run
  task automatic test_wrap();
    u_pctc_partner.run(4097);
    check("bp_wrap_pos35", u_pctc_partner.bp_seen[4095], 1);
    check("bp_wrap_pos36", u_pctc_partner.bp_seen[4096], 0);
    check("lc_wrap_pos31", u_pctc_partner.lc_seen[4095], 1);
    check("lc_wrap_pos32", u_pctc_partner.lc_seen[4096], 0);
    $display("test wrap done");
  endtask : test_wrap
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs about 530 us of link traffic, mostly the full frame
  initial begin
    #700000;
    fail_count++;
    test_done();
  end
  initial begin
    {rst_b, bp_rate16, bp_wr, bp_hiz, lcm_wr, lcm_rd} = 6'h00;
    {local_rate, bp_stream, bp_chan, lcm_stream, lcm_chan, lcm_low, lcm_high} = '0;
    test_reset();
    test_fields();
    test_modes();
    test_streams();
    test_rate16();
    test_wrap();
    test_done();
  end
endmodule : testbench
`default_nettype wire
